// >>> design/tpo_timer.sv
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ns
module tpo_timer (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] srcTick,
    input wire logic lowFreqMode,
    input wire logic lowFreqTick,
    input wire logic timerInPin,
    output logic timerInFilt,
    output logic pulseOutPin,
    output logic timerIrq
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic wrEn = psel & penable & pwrite;
    wire logic hitMode = paddr == tpo_pkg::MODE_OFS;
    wire logic hitCtrl = paddr == tpo_pkg::CTRL_OFS;
    wire logic hitPlo = paddr == tpo_pkg::PCMP_LO_OFS;
    wire logic hitPhi = paddr == tpo_pkg::PCMP_HI_OFS;
    wire logic hitTlo = paddr == tpo_pkg::TCMP_LO_OFS;
    wire logic hitThi = paddr == tpo_pkg::TCMP_HI_OFS;
    wire logic hitStat = paddr == tpo_pkg::STAT_OFS;
    wire logic hitCnt = paddr == tpo_pkg::CNT_OFS;
    wire logic mapped = hitMode | hitCtrl | hitPlo | hitPhi | hitTlo |
        hitThi | hitStat | hitCnt;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    logic [5:0] modeQ;
    tpo_pkg::tpo_ctrl_t ctrlQ;
    logic [7:0] tempQ;
    logic [15:0] pBufQ, tBufQ, pActQ, tActQ, cntQ;
    logic outQ, irqQ, pendQ;
    logic runPrevQ;

    wire logic ppgMode = modeQ[2:0] == tpo_pkg::MODE_PPG; // R1
    wire logic [2:0] ckSel = modeQ[tpo_pkg::MODE_CK_LO +: 3];
    wire logic tick = srcTick[ckSel]; // R1
    wire logic running = ctrlQ.run & ppgMode;
    wire logic counting = running & tick;
    wire logic tMatch = counting & (cntQ == tActQ);
    wire logic pMatch = counting & (cntQ == pActQ);
    wire logic ctrlWr = wrEn & hitCtrl;
    wire logic hiWrP = wrEn & hitPhi;
    wire logic hiWrT = wrEn & hitThi;
    wire logic [15:0] newCmp = {pwdata[7:0], tempQ}; // R13
    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            modeQ <= tpo_pkg::MODE_RST;
            ctrlQ <= tpo_pkg::CTRL_RST;
            tempQ <= 8'h00;
        end else begin
            if (wrEn & hitMode & ~ctrlQ.run)
                modeQ <= pwdata[5:0]; // R4
            if (ctrlWr) begin
                ctrlQ.run <= pwdata[tpo_pkg::CTRL_RUN]; // R4
                ctrlQ.oneshot <= pwdata[tpo_pkg::CTRL_ONESHOT]; // R10
                ctrlQ.dbuf <= pwdata[tpo_pkg::CTRL_DBUF];
                if (!ctrlQ.run) begin
                    ctrlQ.level <= pwdata[tpo_pkg::CTRL_LEVEL]; // R4
                    ctrlQ.ove <= pwdata[tpo_pkg::CTRL_OVE]; // R4
                    ctrlQ.nc <= pwdata[tpo_pkg::CTRL_NC_LO +: 2]; // R20
                end
            end
            if (pMatch & ctrlQ.oneshot)
                ctrlQ.run <= 1'b0; // R7 R10
            if (wrEn & (hitPlo | hitTlo))
                tempQ <= pwdata[7:0]; // R13
        end
    end
    // ------------------------------------------------------------
    // Compare registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            pBufQ <= tpo_pkg::CMP_RST;
            tBufQ <= tpo_pkg::CMP_RST;
            pActQ <= tpo_pkg::CMP_RST;
            tActQ <= tpo_pkg::CMP_RST;
            pendQ <= 1'b0;
        end else begin
            if (hiWrP)
                pBufQ <= newCmp; // R13
            if (hiWrT)
                tBufQ <= newCmp;
            if (hiWrP | hiWrT)
                pendQ <= running & ctrlQ.dbuf;
            if (pMatch & pendQ & ctrlQ.dbuf) begin
                pActQ <= pBufQ; // R11 R15
                tActQ <= tBufQ;
                pendQ <= 1'b0;
            end
            if (hiWrP & ~(running & ctrlQ.dbuf))
                pActQ <= newCmp; // R11 R16
            if (hiWrT & ~(running & ctrlQ.dbuf))
                tActQ <= newCmp; // R11 R16
        end
    end
    // ------------------------------------------------------------
    // Counter and output
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            cntQ <= 16'h0000;
            outQ <= 1'b0;
            irqQ <= 1'b0;
            runPrevQ <= 1'b0;
        end else begin
            runPrevQ <= running;
            irqQ <= pMatch; // R6
            if (!running) begin
                cntQ <= 16'h0000;
                outQ <= ctrlQ.level; // R3 R9
            end else if (pMatch) begin
                cntQ <= 16'h0000; // R8
                outQ <= ctrlQ.level; // R6
            end else begin
                if (counting)
                    cntQ <= cntQ + 16'h0001; // R12 R23
                if (tMatch)
                    outQ <= ~ctrlQ.level; // R5
            end
        end
    end
    assign pulseOutPin = outQ;
    assign timerIrq = irqQ;
    // ------------------------------------------------------------
    // Input noise filter
    // ------------------------------------------------------------
    logic [1:0] syncQ;
    logic [7:0] divQ;
    logic histQ;
    logic [1:0] agreeQ;
    logic filtQ;
    wire logic [7:0] divTop = ctrlQ.nc == 2'b01 ? tpo_pkg::NC_DIV2 :
        ctrlQ.nc == 2'b10 ? tpo_pkg::NC_DIV4 : tpo_pkg::NC_DIV256; // R21
    wire logic fastTick = divQ == divTop;
    wire logic sampTick = lowFreqMode ? lowFreqTick : fastTick; // R22
    wire logic blocked = lowFreqMode & (ctrlQ.nc[0] ^ ctrlQ.nc[1]); // R22
    wire logic filtOn = ctrlQ.nc != 2'b00; // R18
    wire logic samp = syncQ[1];
    always_ff @(posedge clk) begin
        if (srst) begin
            syncQ <= 2'b00;
            divQ <= 8'h00;
            agreeQ <= 2'b00;
            histQ <= 1'b0;
            filtQ <= 1'b0;
        end else begin
            syncQ <= {syncQ[0], timerInPin};
            divQ <= (fastTick | ~filtOn) ? 8'h00 : divQ + 8'h01;
            if (!filtOn) begin
                filtQ <= samp;
                agreeQ <= 2'b00;
            end else if (sampTick & ~blocked) begin
                if (samp == histQ) begin
                    if (agreeQ == 2'(tpo_pkg::FILT_AGREE - 1))
                        filtQ <= samp; // R17
                    else
                        agreeQ <= agreeQ + 2'b01;
                end else
                    agreeQ <= 2'b01;
                histQ <= samp;
            end
        end
    end
    assign timerInFilt = filtQ & ~blocked;
    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        if (hitMode)
            prdata[5:0] = modeQ;
        if (hitCtrl)
            prdata[6:0] = ctrlQ;
        if (hitPlo)
            prdata[7:0] = pBufQ[7:0]; // R15
        if (hitPhi)
            prdata[7:0] = pBufQ[15:8];
        if (hitTlo)
            prdata[7:0] = tBufQ[7:0];
        if (hitThi)
            prdata[7:0] = tBufQ[15:8];
        if (hitStat)
            prdata[2:0] = {filtQ, outQ, runPrevQ};
        if (hitCnt)
            prdata[15:0] = cntQ;
    end
endmodule

// >>> design/tpo_pkg.sv
// Summary of operation
// R1 - Mode field 011 selects pulse output, counting on chosen source clock.
// R2 - Software sets period above toggle value in the two compare registers.
// R3 - Initial level bit sets pin idle level: 1 high, 0 low.
// R4 - Run bit starts counter; mode, overflow enable, level writes ignored running.
// R5 - Toggle compare match drives pin opposite to initial level.
// R6 - Period compare match restores initial level and raises interrupt.
// R7 - One-shot set: period match clears run bit and stops counting.
// R8 - One-shot clear: period match clears counter, counting continues.
// R9 - Run bit falling returns pin to initial level.
// R10 - One-shot bit writable while running; takes effect at period end.
// R11 - Double buffer on: new compares load at period match; off: immediately.
// R12 - Without buffer, compare below count waits for wrap through overflow.
// R13 - Low byte writes go to temp buffer; high byte commits both.
// R14 - Software writes low byte first, then high byte.
// R15 - Buffered: match moves buffer to active; reads return buffer.
// R16 - Writes while stopped update active compare and buffer together.
// R17 - Filter passes new level after three agreeing samples.
// R18 - Filter runs whenever interval field nonzero, regardless of run bit.
// R19 - Software waits four sample intervals before starting timer.
// R20 - Filter interval writes ignored while run bit is 1.
// R21 - Interval 00 off, 01 2, 10 4, 11 256 gear clocks.
// R22 - Low-frequency mode: 11 samples at fs/2, 01 and 10 block input.
// R23 - Up counter is 16 bits wide.
package tpo_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] MODE_OFS = 12'h000;
    localparam logic [11:0] CTRL_OFS = 12'h004;
    localparam logic [11:0] PCMP_LO_OFS = 12'h008;
    localparam logic [11:0] PCMP_HI_OFS = 12'h00c;
    localparam logic [11:0] TCMP_LO_OFS = 12'h010;
    localparam logic [11:0] TCMP_HI_OFS = 12'h014;
    localparam logic [11:0] STAT_OFS = 12'h018;
    localparam logic [11:0] CNT_OFS = 12'h01c;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_ONESHOT = 1;
    localparam int CTRL_LEVEL = 2;
    localparam int CTRL_OVE = 3;
    localparam int CTRL_DBUF = 4;
    localparam int CTRL_NC_LO = 5;
    localparam int MODE_CK_LO = 3;
    localparam logic [2:0] MODE_PPG = 3'h3;
    localparam logic [5:0] MODE_RST = 6'h00;
    localparam logic [15:0] CMP_RST = 16'hffff;
    localparam logic [7:0] NC_DIV2 = 8'h01;
    localparam logic [7:0] NC_DIV4 = 8'h03;
    localparam logic [7:0] NC_DIV256 = 8'hff;
    localparam int FILT_AGREE = 3;
    typedef struct packed {
        logic [1:0] nc;
        logic dbuf;
        logic ove;
        logic level;
        logic oneshot;
        logic run;
    } tpo_ctrl_t;
    localparam tpo_ctrl_t CTRL_RST = '0;
endpackage

// >>> tb/tpo_load.sv
`timescale 1ns/1ns
module tpo_load (
    input wire logic clk,
    input wire logic pulseOutPin,
    input wire logic idleLvl,
    output logic [15:0] lastWidth = '0
);
    logic [15:0] runLen = '0;
    // Length of the last excursion away from the idle level
    always_ff @(posedge clk) begin
        runLen <= (pulseOutPin != idleLvl) ? runLen + 16'h1 : 16'h0;
        if (pulseOutPin == idleLvl && runLen != 16'h0) lastWidth <= runLen;
    end
endmodule

// >>> tb/tpo_timer_checker.sv
`timescale 1ns/1ns
module tpo_timer_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timerInPin,
    input wire logic timerInFilt,
    input wire logic pulseOutPin,
    input wire logic timerIrq
);
    // ----
    // Port checks
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_rdy; psel |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready low");
    property p_errhi;
        psel && penable && paddr > tpo_pkg::CNT_OFS |-> pslverr;
    endproperty
    a_errhi: assert property (p_errhi) else $error("no error");
    property p_errlo;
        psel && penable && paddr <= tpo_pkg::CNT_OFS |-> !pslverr;
    endproperty
    a_errlo: assert property (p_errlo) else $error("bad error");
    property p_rst;
        $fell(srst) |-> !pulseOutPin && !timerIrq && !timerInFilt;
    endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
    property p_irq1; timerIrq |=> !timerIrq; endproperty
    a_irq1: assert property (p_irq1) else $error("irq width");
    property p_irqpin; $rose(timerIrq) |-> $changed(pulseOutPin); endproperty
    a_irqpin: assert property (p_irqpin) else $error("irq pin");
    property p_quiet; $changed(pulseOutPin) |=> $stable(pulseOutPin); endproperty
    a_quiet: assert property (p_quiet) else $error("pin twice");
    property p_filt; $changed(timerInFilt) |-> $past(timerInPin, 3) == timerInFilt
        && $past(timerInPin, 4) == timerInFilt; endproperty
    a_filt: assert property (p_filt) else $error("filter early");
endmodule
bind tpo_timer tpo_timer_checker u_chk (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .timerInPin(timerInPin), .timerInFilt(timerInFilt),
    .pulseOutPin(pulseOutPin), .timerIrq(timerIrq));

// >>> tb/timer_ppg_output_with_input_filter_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t %h %h", $time, a, e); end end
module timer_ppg_output_with_input_filter_tb;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, lowFreqMode = 0, timerInPin = 0, idleLvl = 0;
    logic lowFreqTick = 0;
    logic timerInFilt, pulseOutPin, timerIrq;
    logic [7:0] srcTick = 8'h01;
    logic [15:0] width;
    int failures = 0, testsRun = 0, cyc = 0;
    tpo_timer u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .srcTick(srcTick),
        .lowFreqMode(lowFreqMode), .lowFreqTick(lowFreqTick),
        .timerInPin(timerInPin), .timerInFilt(timerInFilt),
        .pulseOutPin(pulseOutPin), .timerIrq(timerIrq));
    tpo_load u_load (.clk(clk), .pulseOutPin(pulseOutPin),
        .idleLvl(idleLvl), .lastWidth(width));
    // ----
    // Clock, timeout and tasks
    // ----
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        lowFreqTick <= (cyc % 4) == 0;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (failures == 0 && testsRun > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic waitIrq();
        int n = 0;
        while (timerIrq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        `CHK(n < 3000, 1'b1)
        repeat (3) @(posedge clk);
    endtask
    // ----
    // Tests
    // ----
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, tpo_pkg::CTRL_OFS, 32'h0);
        `CHK(rd, 32'(tpo_pkg::CTRL_RST))
        apb(1'b0, 12'h020, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, tpo_pkg::PCMP_LO_OFS, 32'h14);
        apb(1'b1, tpo_pkg::PCMP_HI_OFS, 32'h00);
        apb(1'b1, tpo_pkg::TCMP_LO_OFS, 32'h05);
        apb(1'b1, tpo_pkg::TCMP_HI_OFS, 32'h00);
        apb(1'b1, tpo_pkg::MODE_OFS, 32'(tpo_pkg::MODE_PPG));
        for (int lv = 0; lv < 2; lv++) begin
            idleLvl <= lv[0];
            apb(1'b1, tpo_pkg::CTRL_OFS, {29'h0, lv[0], 2'b00});
            repeat (2) @(posedge clk);
            `CHK(pulseOutPin, lv[0])
            apb(1'b1, tpo_pkg::CTRL_OFS, {29'h0, lv[0], 2'b11});
            apb(1'b1, tpo_pkg::CTRL_OFS, {25'h0, 4'h5, ~lv[0], 2'b11});
            apb(1'b0, tpo_pkg::CTRL_OFS, 32'h0);
            `CHK(rd[6:0], {4'h0, lv[0], 2'b11})
            apb(1'b1, tpo_pkg::MODE_OFS, 32'h0);
            apb(1'b0, tpo_pkg::MODE_OFS, 32'h0);
            `CHK(rd[5:0], 6'h03)
            waitIrq();
            `CHK(width, 16'h000f)
            `CHK(pulseOutPin, lv[0])
            apb(1'b0, tpo_pkg::CTRL_OFS, 32'h0);
            `CHK(rd[0], 1'b0)
        end
        apb(1'b1, tpo_pkg::CTRL_OFS, 32'h05);
        waitIrq();
        waitIrq();
        `CHK(width, 16'h000f)
        apb(1'b1, tpo_pkg::CTRL_OFS, 32'h07);
        waitIrq();
        apb(1'b0, tpo_pkg::CTRL_OFS, 32'h0);
        `CHK(rd[0], 1'b0)
        apb(1'b1, tpo_pkg::CTRL_OFS, 32'h15);
        repeat (8) @(posedge clk);
        apb(1'b1, tpo_pkg::PCMP_LO_OFS, 32'h28);
        apb(1'b1, tpo_pkg::PCMP_HI_OFS, 32'h00);
        apb(1'b0, tpo_pkg::PCMP_LO_OFS, 32'h0);
        `CHK(rd[7:0], 8'h28)
        waitIrq();
        `CHK(width, 16'h000f)
        waitIrq();
        `CHK(width, 16'h0023)
        repeat (10) @(posedge clk);
        apb(1'b1, tpo_pkg::CTRL_OFS, 32'h04);
        repeat (2) @(posedge clk);
        `CHK(pulseOutPin, 1'b1)
        for (int c = 1; c < 4; c++) begin
            int n;
            n = (c == 3) ? 256 : 2 * c;
            apb(1'b1, tpo_pkg::CTRL_OFS, 32'(c << 5));
            timerInPin <= 1'b1;
            repeat (n) @(posedge clk);
            `CHK(timerInFilt, 1'b0)
            repeat (5 * n + 4) @(posedge clk);
            `CHK(timerInFilt, 1'b1)
            timerInPin <= 1'b0;
            repeat (6 * n + 4) @(posedge clk);
            `CHK(timerInFilt, 1'b0)
        end
        lowFreqMode <= 1'b1;
        apb(1'b1, tpo_pkg::CTRL_OFS, 32'h20);
        timerInPin <= 1'b1;
        repeat (30) @(posedge clk);
        `CHK(timerInFilt, 1'b0)
        apb(1'b1, tpo_pkg::CTRL_OFS, 32'h60);
        repeat (30) @(posedge clk);
        `CHK(timerInFilt, 1'b1)
        stop_test();
    end
endmodule
